// *** logic/dup_regs.vh ***
// Constants for the directional under-power element: register map,
// settings layout, reset values and timing counts.
// Assumes a 125 MHz processing clock.
`ifndef DUP_REGS_VH
`define DUP_REGS_VH

// ----------------------------------------
// Register offsets (word index = byte address)
// ----------------------------------------
`define DUP_OFF_CTRL 4'h0
`define DUP_OFF_ANGLE 4'h1
`define DUP_OFF_SPOWER 4'h2
`define DUP_OFF_DELAY 4'h3
`define DUP_OFF_STATUS 4'h4
`define DUP_OFF_PACT 4'h5
`define DUP_OFF_PREACT 4'h6
`define DUP_OFF_EVENT 4'h7
`define DUP_OFF_COS 4'h8
`define DUP_OFF_SIN 4'h9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DUP_CTRL_ENABLE 0
`define DUP_CTRL_START_ONLY 1
`define DUP_EVT_START_CHG 0
`define DUP_EVT_START_VAL 1
`define DUP_EVT_TRIP_CHG 2
`define DUP_EVT_TRIP_VAL 3

// ----------------------------------------
// Reset values and setting limits
// ----------------------------------------
`define DUP_RST_CTRL 2'h0
`define DUP_RST_ANGLE 9'h000
`define DUP_RST_SPOWER 11'h064
`define DUP_SPOWER_MIN 11'h00A
`define DUP_SPOWER_MAX 11'h7D0
`define DUP_RST_DELAY 16'h00C8
`define DUP_DELAY_MIN 16'h00C8
`define DUP_DELAY_MAX 16'hEA60
`define DUP_ANGLE_MIN (-179)
`define DUP_ANGLE_MAX 180
`define DUP_RST_COS 16'h4000
`define DUP_RST_SIN 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define DUP_CLK_MHZ 125
`define DUP_MS_NS 1000000
`define DUP_CLK_NS 8
`define DUP_MS_CYCLES (`DUP_MS_NS / `DUP_CLK_NS)
// Reset ratio 1.05: hysteresis of 5 percent of the start power
`define DUP_HYST_DIV 20

`endif

// *** logic/dup_element.v ***
// Directional under-power element: power calculation, P-Q line decision
// with hysteresis, block gating and definite-time trip delay.
// Assumes fundamental RMS magnitudes and per-phase cos/sin of the U-I
// angle arrive synchronous to i_mclk from the measurement stage.
// Reads return data one cycle after the read strobe, zero otherwise.
//
// How it works
// - P and Q summed from phase products
// - Line through reference point, perpendicular
// - Operate when point nearer origin
// - Threshold raised by hysteresis once operated
// - Start needs decision, no block inputs
// - Operation setting off holds outputs low
// - Start launches trip timer unless start-only
// - Delay 200 to 60000 ms, default 200
// - Start power 1.0 to 200.0 percent
// - Direction angle -179 to 180 degrees
// - Two outputs: general start and trip
// - Each output change logged as event
// - Drop-out at 1.05 times pickup threshold
`timescale 1ns/1ns
`include "dup_regs.vh"

module dup_element
(
  input wire i_mclk,
  input wire i_rst,
  input wire [15:0] i_u1,
  input wire [15:0] i_u2,
  input wire [15:0] i_u3,
  input wire [15:0] i_i1,
  input wire [15:0] i_i2,
  input wire [15:0] i_i3,
  input wire signed [15:0] i_cos1,
  input wire signed [15:0] i_cos2,
  input wire signed [15:0] i_cos3,
  input wire signed [15:0] i_sin1,
  input wire signed [15:0] i_sin2,
  input wire signed [15:0] i_sin3,
  input wire i_general_block_in,
  input wire i_vt_supervision_block_in,
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  output reg o_general_start_out,
  output reg o_general_trip_out,
  output reg o_event
);

  // ----------------------------------------
  // Settings registers
  // ----------------------------------------
  reg [1:0] ctrl_q;
  reg signed [8:0] angle_q;
  reg [10:0] spower_q;
  reg [15:0] delay_q;
  reg signed [15:0] cos_q;
  reg signed [15:0] sin_q;
  reg [3:0] event_q;

  wire enable = ctrl_q[`DUP_CTRL_ENABLE];
  wire start_only = ctrl_q[`DUP_CTRL_START_ONLY];
  wire signed [31:0] wr_s = i_wdata;

  // ----------------------------------------
  // Setting range checks
  // ----------------------------------------
  // direction angle range
  wire angle_ok = (wr_s >= `DUP_ANGLE_MIN) && (wr_s <= `DUP_ANGLE_MAX);
  // start power range, 0.1 percent units
  wire spower_ok = (i_wdata[31:11] == 21'h0)
    && (i_wdata[10:0] >= `DUP_SPOWER_MIN)
    && (i_wdata[10:0] <= `DUP_SPOWER_MAX);
  // delay range in 1 ms steps
  wire delay_ok = (i_wdata[31:16] == 16'h0000)
    && (i_wdata[15:0] >= `DUP_DELAY_MIN)
    && (i_wdata[15:0] <= `DUP_DELAY_MAX);

  // ----------------------------------------
  // Settings write port
  // ----------------------------------------
  // Angle is kept for readback only; the decision uses COS and SIN
  // Out-of-range writes are ignored so the element never runs on an
  // illegal setting; software reads back to confirm.
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_q <= `DUP_RST_CTRL;
      angle_q <= `DUP_RST_ANGLE;
      spower_q <= `DUP_RST_SPOWER;
      delay_q <= `DUP_RST_DELAY;
      cos_q <= `DUP_RST_COS;
      sin_q <= `DUP_RST_SIN;
    end
    else if (i_wr)
    begin
      case (i_addr)
        `DUP_OFF_CTRL:
          ctrl_q <= i_wdata[1:0];
        `DUP_OFF_ANGLE:
          if (angle_ok)
            angle_q <= i_wdata[8:0];
        `DUP_OFF_SPOWER:
          if (spower_ok)
            spower_q <= i_wdata[10:0];
        `DUP_OFF_DELAY:
          if (delay_ok)
            delay_q <= i_wdata[15:0];
        `DUP_OFF_COS:
          cos_q <= i_wdata[15:0];
        `DUP_OFF_SIN:
          sin_q <= i_wdata[15:0];
        default:
          ctrl_q <= ctrl_q;
      endcase
    end
  end

  // ----------------------------------------
  // Power calculation
  // ----------------------------------------
  // Per-phase apparent power U*I, then split by cos/sin (Q1.14).
  // Scaling: the measurement stage delivers U*I so that nominal three-phase
  // power equals 1000 units of 0.1 percent after the >>14 and >>16 shifts.
  wire [31:0] s1 = i_u1 * i_i1;
  wire [31:0] s2 = i_u2 * i_i2;
  wire [31:0] s3 = i_u3 * i_i3;
  wire signed [16:0] s1h = {1'b0, s1[31:16]};
  wire signed [16:0] s2h = {1'b0, s2[31:16]};
  wire signed [16:0] s3h = {1'b0, s3[31:16]};
  // Per-phase products, 17 by 16 bits signed
  wire signed [32:0] p1 = s1h * i_cos1;
  wire signed [32:0] p2 = s2h * i_cos2;
  wire signed [32:0] p3 = s3h * i_cos3;
  wire signed [32:0] q1 = s1h * i_sin1;
  wire signed [32:0] q2 = s2h * i_sin2;
  wire signed [32:0] q3 = s3h * i_sin3;
  reg signed [35:0] p_q;
  reg signed [35:0] q_q;

  // three-phase P and Q, registered every clock
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      p_q <= 36'h0;
      q_q <= 36'h0;
    end
    else
    begin
      p_q <= (p1 + p2 + p3) >>> 14;
      q_q <= (q1 + q2 + q3) >>> 14;
    end
  end

  // ----------------------------------------
  // Directional decision
  // ----------------------------------------
  // Projection of S onto the direction unit vector (cos_q, sin_q, Q1.14),
  // which software sets from the direction angle setting.
  reg signed [52:0] proj_q;
  reg operated_q;
  wire signed [12:0] thr_base = {2'b00, spower_q};
  wire [31:0] hyst_w = spower_q / `DUP_HYST_DIV;
  wire signed [12:0] hyst = {2'b00, hyst_w[10:0]};

  // line through reference point, perpendicular to its direction
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      proj_q <= 53'h0;
    end
    else
    begin
      proj_q <= (p_q * cos_q + q_q * sin_q) >>> 14;
    end
  end

  // ----------------------------------------
  // Hysteresis
  // ----------------------------------------
  // Drop-out needs the power to reach the raised threshold
  // threshold raised while operated; reset ratio 1.05
  wire signed [12:0] thr = operated_q ? (thr_base + hyst) : thr_base;
  // angle beyond +-90 degrees means projection below the line
  wire dir_decision = proj_q < $signed({{40{thr[12]}}, thr});

  // operating time is the measurement stage's plus three cycles
  // gating by both block inputs; operation setting
  wire start_cond = enable && dir_decision
    && !i_general_block_in && !i_vt_supervision_block_in;

  // Operated follows the gated start, so a block also drops the hysteresis
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      operated_q <= 1'b0;
    end
    else
    begin
      operated_q <= start_cond;
    end
  end

  // ----------------------------------------
  // Trip delay
  // ----------------------------------------
  reg [16:0] tick_q;
  reg [15:0] ms_q;
  // Millisecond prescaler: one step per millisecond of clock cycles
  wire tick = (tick_q == `DUP_MS_CYCLES - 1);
  wire trip_arm = start_cond && !start_only;
  wire trip_d = trip_arm
    && (o_general_trip_out
    || (tick && (ms_q + 16'h0001 >= delay_q)));

  // timer runs only while start holds and trip is enabled
  // start loss clears timer and trip
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tick_q <= 17'h0;
      ms_q <= 16'h0;
    end
    else
    begin
      if (!trip_arm)
      begin
        tick_q <= 17'h0;
        ms_q <= 16'h0;
      end
      else if (tick)
      begin
        tick_q <= 17'h0;
        // Saturate so a stuck start cannot wrap the count
        if (ms_q != 16'hFFFF)
          ms_q <= ms_q + 16'h0001;
      end
      else
        tick_q <= tick_q + 17'h00001;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // two registered outputs, start and trip
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_general_start_out <= 1'b0;
      o_general_trip_out <= 1'b0;
    end
    else
    begin
      o_general_start_out <= start_cond;
      o_general_trip_out <= trip_d;
    end
  end

  // ----------------------------------------
  // Events and register reads
  // ----------------------------------------
  wire start_chg = start_cond != o_general_start_out;
  wire trip_chg = trip_d != o_general_trip_out;
  // Reading the event word is what acknowledges it
  wire ev_rd = i_rd && (i_addr == `DUP_OFF_EVENT);

  // One pulse per cycle in which either output changes
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_event <= 1'b0;
    else
      o_event <= start_chg || trip_chg;
  end

  // change flags sticky; a new change wins over the read clear
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      event_q <= 4'h0;
    end
    else
    begin
      event_q[`DUP_EVT_START_VAL] <= start_cond;
      event_q[`DUP_EVT_TRIP_VAL] <= trip_d;
      event_q[`DUP_EVT_START_CHG] <= start_chg || (event_q[`DUP_EVT_START_CHG] && !ev_rd);
      event_q[`DUP_EVT_TRIP_CHG] <= trip_chg || (event_q[`DUP_EVT_TRIP_CHG] && !ev_rd);
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  reg [31:0] rdata_d;

  always @*
  begin
    case (i_addr)
      `DUP_OFF_CTRL:
        rdata_d = {30'h0, ctrl_q};
      `DUP_OFF_ANGLE:
        rdata_d = {{23{angle_q[8]}}, angle_q};
      `DUP_OFF_SPOWER:
        rdata_d = {21'h0, spower_q};
      `DUP_OFF_DELAY:
        rdata_d = {16'h0, delay_q};
      `DUP_OFF_STATUS:
        rdata_d = {29'h0, operated_q, o_general_trip_out, o_general_start_out};
      `DUP_OFF_PACT:
        rdata_d = p_q[31:0];
      `DUP_OFF_PREACT:
        rdata_d = q_q[31:0];
      `DUP_OFF_EVENT:
        rdata_d = {28'h0, event_q};
      `DUP_OFF_COS:
        rdata_d = {{16{cos_q[15]}}, cos_q};
      `DUP_OFF_SIN:
        rdata_d = {{16{sin_q[15]}}, sin_q};
      default:
        rdata_d = 32'h0;
    endcase
  end

  // Zero outside the read slot lets several slaves share an OR bus
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= 32'h0;
    else if (i_rd)
      o_rdata <= rdata_d;
    else
      o_rdata <= 32'h0;
  end

endmodule

// *** bench/dup_properties.sv ***
// Port checker for the under-power element.
// Assumes one clock, i_mclk, and async active-high i_rst.
`timescale 1ns/1ns
module dup_properties
(
  input wire i_mclk,
  input wire i_rst,
  input wire i_general_block_in,
  input wire i_vt_supervision_block_in,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire o_general_start_out,
  input wire o_general_trip_out,
  input wire o_event
);
  // Shortest delay less its 1 percent tolerance, in 8 ns cycles
  localparam int TRIP_MIN = 24750000;
  int run_q;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Saturates so a long start cannot wrap back below the bound
  always @(posedge i_mclk or posedge i_rst)
    if (i_rst || !o_general_start_out)
      run_q <= 0;
    else if (run_q < 1073741824)
      run_q <= run_q + 1;
  a_block_forces_low: assert property (i_general_block_in |=> !o_general_start_out)
    else $error("start high after general block");
  a_vts_forces_low: assert property (i_vt_supervision_block_in |=> !o_general_start_out)
    else $error("start high after supervision block");
  a_start_unblocked: assert property (o_general_start_out |-> !$past(i_general_block_in) && !$past(i_vt_supervision_block_in))
    else $error("start without clear block inputs");
  a_trip_with_start: assert property (o_general_trip_out |-> o_general_start_out)
    else $error("trip without start");
  a_trip_drops_out: assert property ($fell(o_general_start_out) |-> !o_general_trip_out)
    else $error("trip outlived start");
  a_trip_delay_min: assert property ($rose(o_general_trip_out) |-> run_q >= TRIP_MIN)
    else $error("trip before delay");
  a_event_on_rise: assert property ($rose(o_general_start_out) |-> ##[0:1] o_event)
    else $error("no event on start rise");
  a_event_on_fall: assert property ($fell(o_general_start_out) |-> ##[0:1] o_event)
    else $error("no event on start fall");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule
bind dup_element dup_properties i_props (.i_mclk, .i_rst, .i_general_block_in, .i_vt_supervision_block_in,
  .i_rd, .o_rdata, .o_general_start_out, .o_general_trip_out, .o_event);

// *** bench/dup_meas_model.sv ***
// Measurement stage stand-in feeding all three phases alike.
// Assumes the bench gives the active power share of one phase.
`timescale 1ns/1ns
module dup_meas_model
(
  input wire i_mclk,
  input wire [14:0] i_share,
  output reg [15:0] o_u = 16'h8000,
  output reg [15:0] o_i = 16'h0000,
  output reg signed [15:0] o_cos = 16'h4000,
  output reg signed [15:0] o_sin = 16'h2000
);
  // half-scale voltage and doubled current make U*I>>16 the share
  // Nonzero sine gives Q that a zero-angle line must ignore
  always @(posedge i_mclk)
    o_i <= {i_share, 1'b0};
endmodule

// *** bench/dup_testbench.sv ***
// Self-checking bench for the under-power element.
// Assumes default settings after reset; P seen is three times the share.
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module testbench;
  typedef struct packed {logic [14:0] sh; logic b; logic v; logic s;} dup_row_t;
  logic i_mclk = 1'h0;
  logic i_rst = 1'h1;
  logic blk = 1'h0;
  logic voltage_transformer_supervision = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [14:0] share = 15'h0028;
  wire [15:0] mu;
  wire [15:0] mi;
  wire signed [15:0] mc;
  wire signed [15:0] ms;
  wire [31:0] rdata;
  wire start;
  wire trip;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  // Pickup below 100, drop-out at 105 once operated
  dup_row_t rows [9] = '{'{15'h001E, 1'h0, 1'h0, 1'h1}, '{15'h0022, 1'h0, 1'h0, 1'h1},
    '{15'h0023, 1'h0, 1'h0, 1'h0}, '{15'h0022, 1'h0, 1'h0, 1'h0}, '{15'h0021, 1'h0, 1'h0, 1'h1},
    '{15'h0021, 1'h1, 1'h0, 1'h0}, '{15'h0021, 1'h0, 1'h1, 1'h0}, '{15'h0021, 1'h0, 1'h0, 1'h1},
    '{15'h0028, 1'h0, 1'h0, 1'h0}};
  dup_meas_model i_meas (.i_mclk(i_mclk), .i_share(share), .o_u(mu), .o_i(mi), .o_cos(mc), .o_sin(ms));
  dup_element i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_u1(mu), .i_u2(mu), .i_u3(mu), .i_i1(mi), .i_i2(mi),
    .i_i3(mi), .i_cos1(mc), .i_cos2(mc), .i_cos3(mc), .i_sin1(ms), .i_sin2(ms), .i_sin3(ms),
    .i_general_block_in(blk), .i_vt_supervision_block_in(voltage_transformer_supervision), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_general_start_out(start), .o_general_trip_out(trip), .o_event());
  always #4 i_mclk = ~i_mclk;
  // ----
  // Bus tasks and closing
  // ----
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge i_mclk);
    wr <= 1'h0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    addr <= a;
    rd <= 1'h1;
    @(posedge i_mclk);
    rd <= 1'h0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic settle();
    repeat (6) @(posedge i_mclk);
    #1;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    repeat (20) @(posedge i_mclk);
    `CHK({start, trip}, 2'h0)
    i_rst <= 1'h0;
    rd_chk(4'h0, 32'h0);
    rd_chk(4'h2, 32'h64);
    rd_chk(4'h3, 32'hC8);
    rd_chk(4'hF, 32'h0);
    wr_reg(4'h2, 32'h9);
    rd_chk(4'h2, 32'h64);
    wr_reg(4'h3, 32'hEA61);
    rd_chk(4'h3, 32'hC8);
    wr_reg(4'h1, 32'hB4);
    wr_reg(4'h1, 32'hB5);
    rd_chk(4'h1, 32'hB4);
    $display("settings done");
    wr_reg(4'h0, 32'h1);
    foreach (rows[k])
    begin
      @(posedge i_mclk);
      share <= rows[k].sh;
      blk <= rows[k].b;
      voltage_transformer_supervision <= rows[k].v;
      settle();
      `CHK(start, rows[k].s)
      `CHK(trip, 1'h0)
    end
    $display("rows done");
    @(posedge i_mclk);
    share <= 15'h001E;
    settle();
    @(posedge i_mclk);
    i_rst <= 1'h1;
    settle();
    `CHK(start, 1'h0)
    @(posedge i_mclk);
    i_rst <= 1'h0;
    rd_chk(4'h0, 32'h0);
    rd_chk(4'h8, 32'h4000);
    settle();
    `CHK(start, 1'h0)
    wr_reg(4'h0, 32'h3);
    settle();
    `CHK(start, 1'h1)
    rd_chk(4'h4, 32'h5);
    rd_chk(4'h5, 32'h5A);
    rd_chk(4'h6, 32'h2D);
    wr_reg(4'h0, 32'h0);
    settle();
    `CHK(start, 1'h0)
    rd_chk(4'h7, 32'h1);
    rd_chk(4'h7, 32'h0);
    $display("reset and disable done");
    summarize();
  end
endmodule
